// *** logic/effective_address_generator.sv ***
// Effective address generator for a 24-bit processor address space
//
// Contract
// [RQ1] Immediate operand from bytes two (and three)
// [RQ2] Absolute: operand bytes low, data bank high
// [RQ3] Absolute long: three operand bytes form address
// [RQ4] Direct: offset plus direct page, bank zero
// [RQ5] Unaligned direct page costs one extra cycle
// [RQ6] Accumulator and implied: one byte, no address
// [RQ7] (d),y: pointer, data bank prefix, add Y
// [RQ8] [d],y: 24-bit pointer plus Y
// [RQ9] (d,x): pointer at offset+DP+X, data bank
// [RQ10] Short branch: signed offset, bank unchanged
// [RQ11] Long relative: 16-bit add, modulo 65536
// [RQ12] (a): pointer in bank zero, long loads bank
// [RQ13] (d): pointer low, data bank high
// [RQ14] [d]: three pointer bytes are full address
// [RQ15] (a,x): operand plus X, bank zero pointer
// [RQ16] Stack and vector accesses use bank zero
// [RQ17] Stack relative: S plus offset, bank zero
// [RQ18] (d,s),y: pointer at S+offset, 24-bit add Y
// [RQ19] Only long transfers change program bank
// [RQ20] Direct-mode addresses never leave bank zero
// [RQ21] 24-bit data modes carry into bank byte
// [RQ22] Vectors lie in 00FFE0 through 00FFFF
// [RQ23] Emulation stack confined to page one; stack-relative modes still add S plus offset with no page wrap
// [RQ24] Address and valid with the final byte
`timescale 1ns/1ps
module effective_address_generator
  import eag_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Decoder request
  input wire logic req_valid,
  input wire addr_mode_e req_mode,
  input wire logic wide_operand,
  input wire logic long_instr,
  input wire logic [7:0] op_byte2,
  input wire logic [7:0] op_byte3,
  input wire logic [7:0] op_byte4,
  input wire logic [4:0] vector_sel,
  // Pointer bytes fetched by the sequencer
  input wire logic [23:0] ptr_data,
  // Register file
  input wire logic [15:0] direct_page_reg,
  input wire logic [7:0] data_bank_reg,
  input wire logic [7:0] program_bank_reg,
  input wire logic [15:0] pc_next,
  input wire logic [15:0] x_reg,
  input wire logic [15:0] y_reg,
  input wire logic [15:0] stack_ptr,
  input wire logic emulation_mode,
  // Result
  output logic ea_valid,
  output logic [23:0] ea_addr,
  output logic ptr_valid,
  output logic [23:0] ptr_addr,
  output logic [15:0] operand_value,
  output logic operand_valid,
  output logic [7:0] new_pb,
  output logic [15:0] new_pc,
  output logic pc_load,
  output logic extra_cycle,
  output logic no_mem_operand
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    logic ea_valid;
    logic [23:0] ea_addr;
    logic ptr_valid;
    logic [23:0] ptr_addr;
    logic [15:0] operand_value;
    logic operand_valid;
    logic [7:0] new_pb;
    logic [15:0] new_pc;
    logic pc_load;
    logic extra_cycle;
    logic no_mem_operand;
  } eag_state_s;

  eag_state_s st_q;
  eag_state_s st_d;

  // All checks below run on the system clock and sleep through reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // -------------------------------------------------------------------
  // Shared arithmetic
  // -------------------------------------------------------------------
  function automatic logic [23:0] bank0(input logic [15:0] a);
    bank0 = {BANK_ZERO, a}; // RQ16
  endfunction : bank0

  function automatic logic [15:0] stack_wrap(input logic [15:0] a,
                                             input logic emu);
    // Emulation stack is pinned to page one
    stack_wrap = emu ? {EMU_STACK_PAGE, a[7:0]} : a; // RQ23
  endfunction : stack_wrap

  logic [15:0] dp_sum;
  logic [15:0] dpx_sum;
  logic [15:0] sp_sum;
  logic [15:0] absx_sum;
  logic [15:0] rel_sum;
  logic [15:0] brs_sum;
  logic [23:0] ind_y_sum;
  logic [23:0] long_y_sum;
  logic [23:0] srel_y_sum;
  logic [15:0] abs_word;
  logic dp_unaligned;

  assign abs_word = {op_byte3, op_byte2};
  assign dp_unaligned = direct_page_reg[7:0] != DP_ALIGNED;

  eag_add16 u_dp (.base(direct_page_reg), .offset({8'h00, op_byte2}),
    .sum(dp_sum), .carry());
  eag_add16 u_dpx (.base(dp_sum), .offset(x_reg), .sum(dpx_sum),
    .carry());
  eag_add16 u_sp (.base(stack_ptr), .offset({8'h00, op_byte2}),
    .sum(sp_sum), .carry());
  eag_add16 u_absx (.base(abs_word), .offset(x_reg), .sum(absx_sum),
    .carry());
  eag_add16 u_rel (.base(pc_next), .offset(abs_word), .sum(rel_sum),
    .carry());
  eag_add16 u_brs (.base(pc_next), .offset({{8{op_byte2[7]}}, op_byte2}),
    .sum(brs_sum), .carry());

  // Pointer word with data bank prefix ([d],y: full 24-bit pointer), then Y across all 24 bits
  eag_add24 u_ind_y (.base({data_bank_reg, ptr_data[15:0]}), .index(y_reg),
    .sum(ind_y_sum));
  eag_add24 u_long_y (.base(ptr_data), .index(y_reg), .sum(long_y_sum));
  eag_add24 u_srel_y (.base({data_bank_reg, ptr_data[15:0]}),
    .index(y_reg), .sum(srel_y_sum));

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.ea_valid = 1'b0;
    st_d.ptr_valid = 1'b0;
    st_d.operand_valid = 1'b0;
    st_d.pc_load = 1'b0;
    st_d.extra_cycle = 1'b0;
    st_d.no_mem_operand = 1'b0;
    if (req_valid) begin
      unique case (req_mode)
        AM_IMMEDIATE: begin
          st_d.operand_value = wide_operand ? abs_word
                                            : {8'h00, op_byte2}; // RQ1
          st_d.operand_valid = 1'b1;
          st_d.no_mem_operand = 1'b1;
        end
        AM_ABSOLUTE: begin
          st_d.ea_addr = {data_bank_reg, abs_word}; // RQ2
          st_d.ea_valid = 1'b1;
        end
        AM_ABS_LONG: begin
          st_d.ea_addr = {op_byte4, abs_word}; // RQ3
          st_d.ea_valid = 1'b1;
          if (long_instr) begin
            st_d.new_pb = op_byte4; // RQ19
            st_d.new_pc = abs_word;
            st_d.pc_load = 1'b1;
          end
        end
        AM_DIRECT: begin
          st_d.ea_addr = bank0(dp_sum); // RQ4 RQ20
          st_d.ea_valid = 1'b1;
          st_d.extra_cycle = dp_unaligned; // RQ5
        end
        AM_ACCUM, AM_IMPLIED: begin
          st_d.no_mem_operand = 1'b1; // RQ6
        end
        AM_DIR_IND_Y: begin
          st_d.ptr_addr = bank0(dp_sum); // RQ7
          st_d.ptr_valid = 1'b1;
          st_d.ea_addr = ind_y_sum; // RQ21
          st_d.ea_valid = 1'b1;
          st_d.extra_cycle = dp_unaligned; // RQ5
        end
        AM_DIR_IND_LONG_Y: begin
          st_d.ptr_addr = bank0(dp_sum); // RQ8
          st_d.ptr_valid = 1'b1;
          st_d.ea_addr = long_y_sum; // RQ21
          st_d.ea_valid = 1'b1;
          st_d.extra_cycle = dp_unaligned; // RQ5
        end
        AM_DIR_X_IND: begin
          st_d.ptr_addr = bank0(dpx_sum); // RQ9
          st_d.ptr_valid = 1'b1;
          st_d.ea_addr = {data_bank_reg, ptr_data[15:0]};
          st_d.ea_valid = 1'b1;
          st_d.extra_cycle = dp_unaligned; // RQ5
        end
        AM_REL: begin
          // Untaken branches never reach here; the decoder filters them
          st_d.new_pc = brs_sum; // RQ10
          st_d.new_pb = program_bank_reg; // RQ19
          st_d.pc_load = 1'b1;
        end
        AM_REL_LONG: begin
          st_d.ea_addr = {program_bank_reg, rel_sum}; // RQ11
          st_d.new_pc = rel_sum;
          st_d.new_pb = program_bank_reg; // RQ19
          st_d.pc_load = ~long_instr;
          st_d.operand_value = rel_sum;
          st_d.operand_valid = long_instr;
        end
        AM_ABS_IND: begin
          st_d.ptr_addr = bank0(abs_word); // RQ12
          st_d.ptr_valid = 1'b1;
          st_d.new_pc = ptr_data[15:0];
          st_d.new_pb = long_instr ? ptr_data[23:16]
                                   : program_bank_reg; // RQ19
          st_d.pc_load = 1'b1;
        end
        AM_DIR_IND: begin
          st_d.ptr_addr = bank0(dp_sum); // RQ13
          st_d.ptr_valid = 1'b1;
          st_d.ea_addr = {data_bank_reg, ptr_data[15:0]};
          st_d.ea_valid = 1'b1;
          st_d.extra_cycle = dp_unaligned; // RQ5
        end
        AM_DIR_IND_LONG: begin
          st_d.ptr_addr = bank0(dp_sum); // RQ14
          st_d.ptr_valid = 1'b1;
          st_d.ea_addr = ptr_data;
          st_d.ea_valid = 1'b1;
          st_d.extra_cycle = dp_unaligned; // RQ5
        end
        AM_ABS_X_IND: begin
          st_d.ptr_addr = bank0(absx_sum); // RQ15
          st_d.ptr_valid = 1'b1;
          st_d.new_pc = ptr_data[15:0];
          st_d.new_pb = program_bank_reg; // RQ19
          st_d.pc_load = 1'b1;
        end
        AM_STACK: begin
          st_d.ea_addr = bank0(stack_wrap(stack_ptr,
                                          emulation_mode)); // RQ16 RQ23
          st_d.ea_valid = 1'b1;
        end
        AM_STACK_REL: begin
          st_d.ea_addr = bank0(sp_sum); // RQ17
          st_d.ea_valid = 1'b1;
        end
        AM_STACK_REL_IND_Y: begin
          st_d.ptr_addr = bank0(sp_sum); // RQ18
          st_d.ptr_valid = 1'b1;
          st_d.ea_addr = srel_y_sum; // RQ21
          st_d.ea_valid = 1'b1;
        end
        AM_VECTOR: begin
          st_d.ea_addr = VECTOR_LO | {19'h00000,
                                      vector_sel & VECTOR_SEL_MASK}; // RQ22
          st_d.ea_valid = 1'b1;
        end
        default: begin
          st_d.no_mem_operand = 1'b1;
        end
      endcase
    end
  end

  // Result registered the edge after the final byte arrives
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d; // RQ24
    end
  end

  assign ea_valid = st_q.ea_valid;
  assign ea_addr = st_q.ea_addr;
  assign ptr_valid = st_q.ptr_valid;
  assign ptr_addr = st_q.ptr_addr;
  assign operand_value = st_q.operand_value;
  assign operand_valid = st_q.operand_valid;
  assign new_pb = st_q.new_pb;
  assign new_pc = st_q.new_pc;
  assign pc_load = st_q.pc_load;
  assign extra_cycle = st_q.extra_cycle;
  assign no_mem_operand = st_q.no_mem_operand;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  AST_DIRECT_BANK0: assert property ( // RQ20
    req_valid && req_mode == AM_DIRECT |=> ea_addr[23:16] == BANK_ZERO)
    else $error("direct address left bank zero");
  AST_DP_PENALTY: assert property ( // RQ5
    req_valid && req_mode == AM_DIRECT
      |=> extra_cycle == ($past(direct_page_reg[7:0]) != DP_ALIGNED))
    else $error("direct page penalty wrong");
  AST_ABS_ADDR: assert property ( // RQ2
    req_valid && req_mode == AM_ABSOLUTE
      |=> ea_addr == {$past(data_bank_reg), $past(op_byte3),
                      $past(op_byte2)})
    else $error("absolute address wrong");
  AST_LONG_ADDR: assert property ( // RQ3
    req_valid && req_mode == AM_ABS_LONG
      |=> ea_valid && ea_addr[23:16] == $past(op_byte4))
    else $error("long address bank wrong");
  AST_NO_OPERAND: assert property ( // RQ6
    req_valid && (req_mode == AM_ACCUM || req_mode == AM_IMPLIED)
      |=> !ea_valid && !ptr_valid && no_mem_operand)
    else $error("implied mode produced an address");
  AST_BRANCH_PB: assert property ( // RQ10
    req_valid && req_mode == AM_REL
      |=> pc_load && new_pb == $past(program_bank_reg))
    else $error("branch changed program bank");
  AST_STACK_BANK0: assert property ( // RQ16
    req_valid && (req_mode == AM_STACK || req_mode == AM_STACK_REL)
      |=> ea_addr[23:16] == BANK_ZERO)
    else $error("stack access outside bank zero");
  AST_EMU_STACK: assert property ( // RQ23
    req_valid && req_mode == AM_STACK && emulation_mode
      |=> ea_addr[23:8] == {BANK_ZERO, EMU_STACK_PAGE})
    else $error("emulation stack outside page one");
  AST_VECTOR_RANGE: assert property ( // RQ22
    req_valid && req_mode == AM_VECTOR
      |=> ea_addr >= VECTOR_LO && ea_addr <= VECTOR_HI)
    else $error("vector out of range");
  AST_IND_Y_CARRY: assert property ( // RQ21
    req_valid && req_mode == AM_DIR_IND_Y
      |=> ea_addr == {$past(data_bank_reg), $past(ptr_data[15:0])}
                     + {8'h00, $past(y_reg)})
    else $error("indirect Y sum wrong");
  AST_ONE_CYCLE: assert property ( // RQ24
    !req_valid |=> !ea_valid && !pc_load)
    else $error("result without request");

endmodule : effective_address_generator

// *** logic/eag_pkg.sv ***
// Package: mode codes, bank and vector constants for the address generator
package eag_pkg;

  // ---------------------------------------------------------------------
  // Addressing modes
  // ---------------------------------------------------------------------
  typedef enum logic [4:0] {
    AM_IMMEDIATE,
    AM_ABSOLUTE,
    AM_ABS_LONG,
    AM_DIRECT,
    AM_ACCUM,
    AM_IMPLIED,
    AM_DIR_IND_Y,
    AM_DIR_IND_LONG_Y,
    AM_DIR_X_IND,
    AM_REL,
    AM_REL_LONG,
    AM_ABS_IND,
    AM_DIR_IND,
    AM_DIR_IND_LONG,
    AM_ABS_X_IND,
    AM_STACK,
    AM_STACK_REL,
    AM_STACK_REL_IND_Y,
    AM_VECTOR
  } addr_mode_e;

  // ---------------------------------------------------------------------
  // Fixed values
  // ---------------------------------------------------------------------
  localparam logic [7:0] BANK_ZERO = 8'h00;
  localparam logic [7:0] EMU_STACK_PAGE = 8'h01;
  localparam logic [23:0] VECTOR_LO = 24'h00FFE0;
  localparam logic [23:0] VECTOR_HI = 24'h00FFFF;
  localparam logic [4:0] VECTOR_SEL_MASK = 5'h1F;
  localparam logic [7:0] DP_ALIGNED = 8'h00;
  localparam logic [1:0] PENALTY_CYCLES = 2'h1;
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

endpackage : eag_pkg

// *** logic/eag_add16.sv ***
// Sixteen-bit base plus offset adder with carry out
`timescale 1ns/1ps
module eag_add16
  import eag_pkg::*;
(
  // Operands
  input wire logic [15:0] base,
  input wire logic [15:0] offset,
  // Result
  output logic [15:0] sum,
  output logic carry
);

  always_comb begin
    {carry, sum} = {1'b0, base} + {1'b0, offset};
  end

endmodule : eag_add16

// *** logic/eag_add24.sv ***
// Twenty-four-bit adder: carries reach the bank byte
`timescale 1ns/1ps
module eag_add24
  import eag_pkg::*;
(
  // Operands
  input wire logic [23:0] base,
  input wire logic [15:0] index,
  // Result
  output logic [23:0] sum
);

  always_comb begin
    sum = base + {8'h00, index};
  end

endmodule : eag_add24

// *** tb/eag_decoder_model.sv ***
// Decoder and register file model driving the address generator
`timescale 1ns/1ps
module eag_decoder_model
  import eag_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Request
  output logic req_valid,
  output addr_mode_e req_mode,
  output logic wide_operand,
  output logic long_instr,
  output logic [7:0] op_byte2,
  output logic [7:0] op_byte3,
  output logic [7:0] op_byte4,
  output logic [4:0] vector_sel,
  output logic [23:0] ptr_data,
  // Register file
  output logic [15:0] direct_page_reg,
  output logic [7:0] data_bank_reg,
  output logic [7:0] program_bank_reg,
  output logic [15:0] pc_next,
  output logic [15:0] x_reg,
  output logic [15:0] y_reg,
  output logic [15:0] stack_ptr,
  output logic emulation_mode
);
  initial begin
    req_valid = 1'b0;
    req_mode = AM_IMPLIED;
    wide_operand = 1'b0;
    long_instr = 1'b0;
    op_byte2 = 8'h00;
    op_byte3 = 8'h00;
    op_byte4 = 8'h00;
    vector_sel = 5'h00;
    ptr_data = 24'h000000;
    direct_page_reg = 16'h0100;
    data_bank_reg = 8'hC3;
    program_bank_reg = 8'h7E;
    pc_next = 16'hFFF0;
    x_reg = 16'h0102;
    y_reg = 16'h8000;
    stack_ptr = 16'h01F0;
    emulation_mode = 1'b0;
  end

  // Present one request with its final bytes and pointer already fetched
  task automatic issue(input addr_mode_e m, input logic f,
                       input logic [7:0] b2, input logic [7:0] b3,
                       input logic [7:0] b4, input logic [23:0] p,
                       input logic [15:0] d);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_mode <= m;
    wide_operand <= f;
    long_instr <= f;
    op_byte2 <= b2;
    op_byte3 <= b3;
    op_byte4 <= b4;
    vector_sel <= b2[4:0];
    ptr_data <= p;
    direct_page_reg <= d;
  endtask : issue

  // Released lines flip so stale bytes are never mistaken for live ones
  task automatic idle();
    @(posedge clk_sys);
    req_valid <= 1'b0;
    ptr_data <= ~ptr_data;
    op_byte2 <= ~op_byte2;
    op_byte3 <= ~op_byte3;
    op_byte4 <= ~op_byte4;
  endtask : idle

  // Register file update, applied on the edge the caller stands at
  task automatic set_stack(input logic [15:0] s, input logic e);
    stack_ptr <= s;
    emulation_mode <= e;
  endtask : set_stack
endmodule : eag_decoder_model

// *** tb/effective_address_generator_test.sv ***
// Self-checking bench for the effective address generator
`timescale 1ns/1ps
module effective_address_generator_test
  import eag_pkg::*;
;
  typedef struct {
    addr_mode_e m;
    logic f;
    logic [7:0] b2, b3, b4;
    logic [23:0] p;
    logic [15:0] d;
    logic [1:0] k;
    logic x;
    logic [23:0] e;
  } row_s;

  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid, wide_operand, long_instr, emulation_mode;
  addr_mode_e req_mode;
  logic [7:0] op_byte2, op_byte3, op_byte4, data_bank_reg, program_bank_reg;
  logic [4:0] vector_sel;
  logic [23:0] ptr_data, ea_addr, ptr_addr;
  logic [15:0] direct_page_reg, pc_next, x_reg, y_reg, stack_ptr;
  logic ea_valid, ptr_valid, operand_valid, pc_load, extra_cycle;
  logic no_mem_operand;
  logic [15:0] operand_value, new_pc;
  logic [7:0] new_pb;
  logic [24:0] got;
  int failures = 0;
  int checks = 0;

  // Kind 0 data address, 1 program counter load, 2 operand value
  row_s rows[23] = '{
    '{AM_IMMEDIATE, 1, 8'h34, 8'h12, 8'h00, 0, 16'h0100, 2, 0, 24'h001234},
    '{AM_ABSOLUTE, 0, 8'hCD, 8'hAB, 8'h00, 0, 16'h0100, 0, 0, 24'hC3ABCD},
    '{AM_ABS_LONG, 0, 8'h56, 8'h34, 8'h12, 0, 16'h0100, 0, 0, 24'h123456},
    '{AM_DIRECT, 0, 8'h20, 8'h00, 8'h00, 0, 16'h0100, 0, 0, 24'h000120},
    '{AM_DIRECT, 0, 8'h20, 8'h00, 8'h00, 0, 16'hFFF1, 0, 1, 24'h000011},
    '{AM_DIR_IND_Y, 0, 8'h20, 0, 0, 24'h00F000, 16'h0100, 0, 0, 24'hC47000},
    '{AM_DIR_IND_LONG_Y, 0, 8'h20, 0, 0, 24'h12C000, 16'h00F1, 0, 1,
      24'h134000},
    '{AM_DIR_X_IND, 0, 8'h20, 0, 0, 24'h005678, 16'h0100, 0, 0, 24'hC35678},
    '{AM_REL, 0, 8'h80, 8'h00, 8'h00, 0, 16'h0100, 1, 0, 24'h7EFF70},
    '{AM_REL, 0, 8'h10, 8'h00, 8'h00, 0, 16'h0100, 1, 0, 24'h7E0000},
    '{AM_REL_LONG, 0, 8'h20, 8'h00, 8'h00, 0, 16'h0100, 1, 0, 24'h7E0010},
    '{AM_REL_LONG, 1, 8'h20, 8'h00, 8'h00, 0, 16'h0100, 2, 0, 24'h000010},
    '{AM_ABS_IND, 0, 8'h00, 8'h30, 0, 24'hAB1234, 16'h0100, 1, 0, 24'h7E1234},
    '{AM_ABS_IND, 1, 8'h00, 8'h30, 0, 24'hAB1234, 16'h0100, 1, 0, 24'hAB1234},
    '{AM_DIR_IND, 0, 8'h20, 0, 0, 24'h009ABC, 16'h0100, 0, 0, 24'hC39ABC},
    '{AM_DIR_IND_LONG, 0, 8'h20, 0, 0, 24'h345678, 16'h0100, 0, 0,
      24'h345678},
    '{AM_ABS_X_IND, 0, 8'h00, 8'h30, 0, 24'h004321, 16'h0100, 1, 0,
      24'h7E4321},
    '{AM_STACK, 0, 8'h00, 8'h00, 8'h00, 0, 16'h0100, 0, 0, 24'h0001F0},
    '{AM_STACK_REL, 0, 8'hFF, 8'h00, 8'h00, 0, 16'h0100, 0, 0, 24'h0002EF},
    '{AM_STACK_REL_IND_Y, 0, 8'h04, 0, 0, 24'h00FF00, 16'h0100, 0, 0,
      24'hC47F00},
    '{AM_VECTOR, 0, 8'h1C, 8'h00, 8'h00, 0, 16'h0100, 0, 0, 24'h00FFFC},
    '{AM_ABS_LONG, 1, 8'h56, 8'h34, 8'h12, 0, 16'h0100, 1, 0, 24'h123456},
    '{AM_IMMEDIATE, 0, 8'h34, 8'h12, 8'h00, 0, 16'h0100, 2, 0, 24'h000034}
  };

  always #2 clk_sys = ~clk_sys;

  eag_decoder_model eag_decoder_model_i (.clk_sys, .req_valid, .req_mode,
    .wide_operand, .long_instr, .op_byte2, .op_byte3, .op_byte4, .vector_sel,
    .ptr_data, .direct_page_reg, .data_bank_reg, .program_bank_reg, .pc_next,
    .x_reg, .y_reg, .stack_ptr, .emulation_mode);

  effective_address_generator effective_address_generator_i (.clk_sys,
    .rst_b, .req_valid, .req_mode, .wide_operand, .long_instr, .op_byte2,
    .op_byte3, .op_byte4, .vector_sel, .ptr_data, .direct_page_reg,
    .data_bank_reg, .program_bank_reg, .pc_next, .x_reg, .y_reg, .stack_ptr,
    .emulation_mode, .ea_valid, .ea_addr, .ptr_valid, .ptr_addr,
    .operand_value, .operand_valid, .new_pb, .new_pc, .pc_load, .extra_cycle,
    .no_mem_operand);

  task automatic chk(input string name, input logic [24:0] seen,
                     input logic [24:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // Generous margin over the expected 66 cycles
  initial begin
    repeat (2000) @(posedge clk_sys);
    failures++;
    final_report();
  end

  initial begin
    #5;
    chk("reset", {ea_valid, ea_addr}, 25'h0);
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      eag_decoder_model_i.issue(rows[i].m, rows[i].f, rows[i].b2,
                                rows[i].b3, rows[i].b4, rows[i].p, rows[i].d);
      eag_decoder_model_i.idle();
      #1;
      case (rows[i].k)
        2'h0: got = {ea_valid, ea_addr};
        2'h1: got = {pc_load, new_pb, new_pc};
        default: got = {operand_valid, 8'h00, operand_value};
      endcase
      chk("result", got, {1'b1, rows[i].e});
      chk("penalty", {24'h0, extra_cycle}, {24'h0, rows[i].x});
    end
    // Single-byte modes yield no memory address
    for (int i = 0; i < 2; i++) begin
      eag_decoder_model_i.issue(i ? AM_IMPLIED : AM_ACCUM, 0, 8'h55, 8'h66,
                                8'h77, 0, 16'h0100);
      eag_decoder_model_i.idle();
      #1;
      chk("no_mem", {23'h0, no_mem_operand, ea_valid}, 25'h2);
    end
    // Back-to-back requests, pointer location includes X
    eag_decoder_model_i.issue(AM_DIR_X_IND, 0, 8'h20, 0, 0, 24'h001111,
                              16'h0100);
    eag_decoder_model_i.issue(AM_ABSOLUTE, 0, 8'h01, 8'h02, 8'h00, 0,
                              16'h0100);
    #1;
    chk("ptr_addr", {ptr_valid, ptr_addr}, {1'b1, 24'h000222});
    chk("first", {ea_valid, ea_addr}, {1'b1, 24'hC31111});
    eag_decoder_model_i.idle();
    #1;
    chk("second", {ea_valid, ea_addr}, {1'b1, 24'hC30201});
    @(posedge clk_sys);
    #1;
    chk("hold", {ea_valid, ea_addr}, {1'b0, 24'hC30201});
    // Emulation keeps the stack in page one
    @(posedge clk_sys);
    eag_decoder_model_i.set_stack(16'h12F0, 1'b1);
    eag_decoder_model_i.issue(AM_STACK, 0, 8'h00, 8'h00, 8'h00, 0, 16'h0100);
    eag_decoder_model_i.idle();
    #1;
    chk("emu_stack", {ea_valid, ea_addr}, {1'b1, 24'h0001F0});
    // Mid-run reset clears held results; first edge after it stays quiet
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("mid_reset", {ea_valid, ea_addr}, 25'h0);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    eag_decoder_model_i.set_stack(16'h01F0, 1'b0);
    eag_decoder_model_i.issue(AM_DIRECT, 0, 8'h20, 8'h00, 8'h00, 0, 16'h0100);
    #1;
    chk("quiet", {23'h0, ea_valid, pc_load}, 25'h0);
    eag_decoder_model_i.idle();
    #1;
    chk("after_reset", {ea_valid, ea_addr}, {1'b1, 24'h000120});
    final_report();
  end
endmodule : effective_address_generator_test
